//--- rtl/eic_pkg.sv
// Shared constants and types for the encoder index event block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package eic_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int EIC_ADDR_W = 8;
  // Word indexes; the byte address is four times the index
  localparam logic [5:0] EIC_IDX_CONFIG = 6'h07;
  localparam logic [5:0] EIC_IDX_RST_VAL = 6'h08;
  localparam logic [5:0] EIC_IDX_POS = 6'h09;
  localparam logic [5:0] EIC_IDX_ENC_LATCH = 6'h0A;
  localparam logic [5:0] EIC_IDX_STEP_LATCH = 6'h0B;
  localparam logic [5:0] EIC_IDX_STATUS = 6'h0C;

  localparam logic [31:0] EIC_CONFIG_RST = 32'h0000_0400;
  localparam logic [31:0] EIC_WORD_RST = 32'h0000_0000;

  // ****************************************************************
  // Configuration field positions
  // ****************************************************************
  localparam int EIC_B_DECIMAL = 0;
  localparam int EIC_B_CLEAR = 1;
  localparam int EIC_B_CONT = 2;
  localparam int EIC_B_ONCE = 3;
  localparam int EIC_B_POL_N = 4;
  localparam int EIC_B_SENS_LO = 5;
  localparam int EIC_B_SENS_HI = 6;
  localparam int EIC_B_POL_A = 7;
  localparam int EIC_B_POL_B = 8;
  localparam int EIC_B_SKIP_AB = 9;
  localparam int EIC_B_LATCH_ENC = 10;
  localparam int EIC_B_LATCH_STEP = 11;

  // Status register fields
  localparam int EIC_S_N = 0;
  localparam int EIC_S_A = 1;
  localparam int EIC_S_B = 2;
  localparam int EIC_S_ARMED = 3;
  localparam int EIC_S_CNT_LO = 16;

  localparam logic [1:0] EIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EIC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    EIC_SENS_LEVEL = 2'h0,
    EIC_SENS_TO_ACT = 2'h1,
    EIC_SENS_TO_INACT = 2'h2,
    EIC_SENS_BOTH = 2'h3
  } eic_sens_t;

  typedef struct packed {
    logic pol_n;
    eic_sens_t sens;
    logic pol_a;
    logic pol_b;
    logic index_skip_quadrature_gating;
  } eic_idx_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [EIC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [EIC_ADDR_W-1:0] araddr;
    logic rready;
  } eic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eic_axi_rsp_t;

endpackage : eic_pkg

//--- rtl/eic_sync.sv
// Two-flop synchroniser, one lane per bit.
// Assumes asynchronous pin inputs and one system clock.
`timescale 1ns/10ps
`default_nettype none
module eic_sync
  import eic_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);

  logic [W-1:0] stage1;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_lane
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          stage1[gi] <= 1'b0;
          sync[gi] <= 1'b0;
        end else begin
          stage1[gi] <= pin[gi];
          sync[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

endmodule : eic_sync
`default_nettype wire

//--- rtl/eic_idx_qual.sv
// Index event qualifier: polarity, sensitivity and A/B level gating.
// Assumes synchronised A, B and N levels on the system clock.
`timescale 1ns/10ps
`default_nettype none
module eic_idx_qual
  import eic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic n_lvl,
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire eic_idx_cfg_t cfg,
  output logic event_hit
);

  logic n_act;
  logic n_act_q;
  logic to_act;
  logic to_inact;
  logic sens_hit;
  logic ab_ok;

  assign n_act = ~(n_lvl ^ cfg.pol_n);
  assign to_act = n_act & ~n_act_q;
  assign to_inact = ~n_act & n_act_q;

  always_comb begin
    unique case (cfg.sens)
      EIC_SENS_LEVEL: sens_hit = n_act;
      EIC_SENS_TO_ACT: sens_hit = to_act;
      EIC_SENS_TO_INACT: sens_hit = to_inact;
      EIC_SENS_BOTH: sens_hit = to_act | to_inact;
    endcase
  end

  assign ab_ok = cfg.index_skip_quadrature_gating
    | ((a_lvl == cfg.pol_a) & (b_lvl == cfg.pol_b));
  assign event_hit = sens_hit & ab_ok;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      n_act_q <= 1'b0;
    end else begin
      n_act_q <= n_act;
    end
  end

endmodule : eic_idx_qual
`default_nettype wire

//--- rtl/eic_top.sv
// Encoder index event configuration block with AXI4-Lite registers.
// Holds the encoder position counter, its reset value and both latches.
// Assumes A, B, N arrive asynchronously from pins and the actual step
// position comes from logic on the same system clock.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Config bit 0 selects binary or decimal encoder constant, ABN only.
// - Config bit 1 loads position with reset value on qualified index.
// - Config bit 2 clears/latches on every qualified index event.
// - Config bit 3 clears/latches only on the next qualified event.
// - Hardware returns bit 3 to zero after that single action.
// - Config bit 4 selects index active low (0) or high (1).
// - Sensitivity 0: event active while index at active level.
// - Sensitivity 1: event on transition into active level.
// - Sensitivity 2: event on transition into inactive level.
// - Sensitivity 3: event on both index transitions.
// - Config bit 7 gives the A level required for a valid event.
// - Config bit 8 gives the B level required for a valid event.
// - Config bit 9 set ignores A and B levels entirely.
// - Configuration register resets to 0x00000400, host read/write.
// - Config bit 10 latches encoder position on index events.
// - Config bit 11 latches actual step position on index events.
module eic_top
  import eic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire eic_axi_req_t axi_req,
  output var eic_axi_rsp_t axi_rsp,
  input wire logic enc_a_pin,
  input wire logic enc_b_pin,
  input wire logic enc_n_pin,
  input wire logic [31:0] actual_step_position,
  output logic [31:0] enc_pos,
  output logic [31:0] enc_latch,
  output logic [31:0] step_latch,
  output logic enc_decimal_mode,
  output logic index_pulse
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic {
    EIC_WR_IDLE = 1'b0,
    EIC_WR_RESP = 1'b1
  } eic_wr_state_t;

  typedef enum logic {
    EIC_RD_IDLE = 1'b0,
    EIC_RD_DATA = 1'b1
  } eic_rd_state_t;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0] config_reg;
  logic [31:0] rst_val;
  logic [15:0] event_count;
  logic [2:0] pins_sync;
  logic a_lvl;
  logic b_lvl;
  logic n_lvl;
  logic a_prev;
  logic b_prev;
  eic_idx_cfg_t idx_cfg;
  logic event_hit;

  eic_wr_state_t wr_state;
  eic_wr_state_t next_wr_state;
  eic_rd_state_t rd_state;
  eic_rd_state_t next_rd_state;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [EIC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic wr_go;

  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_cfg;
  logic wr_rst;
  logic wr_pos;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  logic armed;
  logic act;
  logic do_clear;
  logic do_latch_enc;
  logic do_latch_step;
  logic once_done;
  logic q_step;
  logic q_up;
  logic [31:0] next_config;
  logic [31:0] next_pos;

  // ****************************************************************
  // Input synchronisation and index qualification
  // ****************************************************************
  eic_sync #(
    .W(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin({enc_n_pin, enc_b_pin, enc_a_pin}),
    .sync(pins_sync)
  );

  assign a_lvl = pins_sync[0];
  assign b_lvl = pins_sync[1];
  assign n_lvl = pins_sync[2];

  assign idx_cfg = '{
    pol_n: config_reg[EIC_B_POL_N],
    sens: eic_sens_t'(config_reg[EIC_B_SENS_HI:EIC_B_SENS_LO]),
    pol_a: config_reg[EIC_B_POL_A],
    pol_b: config_reg[EIC_B_POL_B],
    index_skip_quadrature_gating: config_reg[EIC_B_SKIP_AB]
  };

  eic_idx_qual u_qual (
    .clk_sys(clk_sys),
    .srst(srst),
    .n_lvl(n_lvl),
    .a_lvl(a_lvl),
    .b_lvl(b_lvl),
    .cfg(idx_cfg),
    .event_hit(event_hit)
  );

  // ****************************************************************
  // Index actions
  // ****************************************************************
  assign armed = config_reg[EIC_B_CONT] | config_reg[EIC_B_ONCE];
  assign act = event_hit & armed;
  assign do_clear = act & config_reg[EIC_B_CLEAR];
  assign do_latch_enc = act & config_reg[EIC_B_LATCH_ENC];
  assign do_latch_step = act & config_reg[EIC_B_LATCH_STEP];
  assign once_done = event_hit & config_reg[EIC_B_ONCE];

  // Quadrature decode: exactly one of A and B changed
  assign q_step = (a_lvl ^ a_prev) ^ (b_lvl ^ b_prev);
  assign q_up = a_prev ^ b_lvl;

  // ****************************************************************
  // AXI4-Lite handshakes and decode
  // ****************************************************************
  assign aw_fire = axi_req.awvalid & axi_rsp.awready;
  assign w_fire = axi_req.wvalid & axi_rsp.wready;
  assign b_fire = axi_rsp.bvalid & axi_req.bready;
  assign ar_fire = axi_req.arvalid & axi_rsp.arready;
  assign r_fire = axi_rsp.rvalid & axi_req.rready;
  assign wr_go = (wr_state == EIC_WR_IDLE) & aw_held & w_held;

  assign next_aw_held = (aw_held | aw_fire) & ~wr_go;
  assign next_w_held = (w_held | w_fire) & ~wr_go;

  always_comb begin
    next_wr_state = wr_state;
    unique case (wr_state)
      EIC_WR_IDLE: if (wr_go) next_wr_state = EIC_WR_RESP;
      EIC_WR_RESP: if (b_fire) next_wr_state = EIC_WR_IDLE;
    endcase
  end

  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      EIC_RD_IDLE: if (ar_fire) next_rd_state = EIC_RD_DATA;
      EIC_RD_DATA: if (r_fire) next_rd_state = EIC_RD_IDLE;
    endcase
  end

  assign wr_idx = awaddr_q[7:2];
  assign rd_idx = axi_req.araddr[7:2];
  assign wr_cfg = wr_go & (wr_idx == EIC_IDX_CONFIG);
  assign wr_rst = wr_go & (wr_idx == EIC_IDX_RST_VAL);
  assign wr_pos = wr_go & (wr_idx == EIC_IDX_POS);
  assign wr_hit = (wr_idx == EIC_IDX_CONFIG)
    | (wr_idx == EIC_IDX_RST_VAL) | (wr_idx == EIC_IDX_POS);

  assign status_word = {event_count, 12'h000,
    config_reg[EIC_B_ONCE], b_lvl, a_lvl, n_lvl};

  assign rd_hit = (rd_idx == EIC_IDX_CONFIG)
    | (rd_idx == EIC_IDX_RST_VAL) | (rd_idx == EIC_IDX_POS)
    | (rd_idx == EIC_IDX_ENC_LATCH) | (rd_idx == EIC_IDX_STEP_LATCH)
    | (rd_idx == EIC_IDX_STATUS);

  assign rd_word =
    (rd_idx == EIC_IDX_CONFIG) ? config_reg :
    (rd_idx == EIC_IDX_RST_VAL) ? rst_val :
    (rd_idx == EIC_IDX_POS) ? enc_pos :
    (rd_idx == EIC_IDX_ENC_LATCH) ? enc_latch :
    (rd_idx == EIC_IDX_STEP_LATCH) ? step_latch :
    (rd_idx == EIC_IDX_STATUS) ? status_word : 32'h0000_0000;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // A host write arming the one-shot wins over its hardware clear
  always_comb begin
    next_config = config_reg;
    if (wr_cfg) begin
      next_config = merge(config_reg, wdata_q, wstrb_q);
    end else if (once_done) begin
      next_config[EIC_B_ONCE] = 1'b0;
    end
  end

  // Host write first, then index clear, then quadrature count
  always_comb begin
    next_pos = enc_pos;
    if (wr_pos) begin
      next_pos = merge(enc_pos, wdata_q, wstrb_q);
    end else if (do_clear) begin
      next_pos = rst_val;
    end else if (q_step) begin
      next_pos = q_up ? enc_pos + 32'h0000_0001
                      : enc_pos - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Bus registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_state <= EIC_WR_IDLE;
      rd_state <= EIC_RD_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) awaddr_q <= axi_req.awaddr;
      if (w_fire) wdata_q <= axi_req.wdata;
      if (w_fire) wstrb_q <= axi_req.wstrb;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready <= 1'b0;
      axi_rsp.bvalid <= 1'b0;
      axi_rsp.bresp <= EIC_RESP_OKAY;
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.rdata <= 32'h0000_0000;
      axi_rsp.rresp <= EIC_RESP_OKAY;
    end else begin
      axi_rsp.awready <= (next_wr_state == EIC_WR_IDLE) & ~next_aw_held;
      axi_rsp.wready <= (next_wr_state == EIC_WR_IDLE) & ~next_w_held;
      axi_rsp.bvalid <= (next_wr_state == EIC_WR_RESP);
      if (wr_go) begin
        axi_rsp.bresp <= wr_hit ? EIC_RESP_OKAY : EIC_RESP_SLVERR;
      end
      axi_rsp.arready <= (next_rd_state == EIC_RD_IDLE);
      axi_rsp.rvalid <= (next_rd_state == EIC_RD_DATA);
      if (ar_fire) begin
        axi_rsp.rdata <= rd_word;
        axi_rsp.rresp <= rd_hit ? EIC_RESP_OKAY : EIC_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Configuration and position registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      config_reg <= EIC_CONFIG_RST;
      rst_val <= EIC_WORD_RST;
    end else begin
      config_reg <= next_config;
      if (wr_rst) rst_val <= merge(rst_val, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_pos <= EIC_WORD_RST;
      a_prev <= 1'b0;
      b_prev <= 1'b0;
    end else begin
      enc_pos <= next_pos;
      a_prev <= a_lvl;
      b_prev <= b_lvl;
    end
  end

  // Latches take the position as it stood before a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_latch <= EIC_WORD_RST;
      step_latch <= EIC_WORD_RST;
    end else begin
      if (do_latch_enc) enc_latch <= enc_pos;
      if (do_latch_step) step_latch <= actual_step_position;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      event_count <= 16'h0000;
      index_pulse <= 1'b0;
      enc_decimal_mode <= 1'b0;
    end else begin
      if (event_hit) event_count <= event_count + 16'h0001;
      index_pulse <= event_hit;
      enc_decimal_mode <= next_config[EIC_B_DECIMAL];
    end
  end

endmodule : eic_top
`default_nettype wire

//--- testbench/eic_top_chk_sva.sv
// Port checker for the encoder index event block.
// Assumes it is bound to eic_top, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module eic_top_chk
  import eic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire eic_axi_req_t axi_req,
  input wire eic_axi_rsp_t axi_rsp,
  input wire logic [31:0] actual_step_position,
  input wire logic [31:0] enc_pos,
  input wire logic [31:0] enc_latch,
  input wire logic [31:0] step_latch,
  input wire logic enc_decimal_mode,
  input wire logic index_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire aw_hs = axi_req.awvalid && axi_rsp.awready;
  wire w_hs = axi_req.wvalid && axi_rsp.wready;
  wire ar_hs = axi_req.arvalid && axi_rsp.arready;
  // ******
  // Assertions
  // ******
  AST_RST_VALUES: assert property ($fell(srst) |-> enc_pos == 32'h0 &&
    enc_latch == 32'h0 && !enc_decimal_mode && !index_pulse)
    else $error("registers not cleared by reset");
  AST_WR_LATENCY: assert property (aw_hs && w_hs |=>
    !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response not two edges after handshake");
  AST_RD_LATENCY: assert property (ar_hs |=> axi_rsp.rvalid)
    else $error("read data not one edge after handshake");
  AST_RD_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before rready");
  AST_WR_RETURN: assert property (axi_rsp.bvalid && axi_req.bready |=>
    axi_rsp.awready && axi_rsp.wready)
    else $error("write channels not ready after response");
  AST_DECIMAL: assert property ($changed(enc_decimal_mode) |->
    $rose(axi_rsp.bvalid))
    else $error("decimal mode changed without a register write");
  AST_ENC_LATCH: assert property ($changed(enc_latch) |->
    index_pulse && enc_latch == $past(enc_pos))
    else $error("encoder latch not taken at an index event");
  AST_STEP_LATCH: assert property ($changed(step_latch) |->
    index_pulse && step_latch == $past(actual_step_position))
    else $error("step latch not taken at an index event");
endmodule : eic_top_chk
`default_nettype wire

//--- testbench/eic_enc_model.sv
// Incremental A/B/N encoder model driving the pins.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module eic_enc_model (
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  logic [1:0] q = 2'h0;
  logic n_q = 1'b1;
  // Gray order 00,01,11,10 on A,B: one line moves per step
  assign enc_a = q[1];
  assign enc_b = q[1] ^ q[0];
  assign enc_n = n_q;
  task step();
    q <= q + 2'h1;
  endtask : step
  task set_n(input logic v);
    n_q <= v;
  endtask : set_n
endmodule : eic_enc_model
`default_nettype wire

//--- testbench/encoder_index_event_config_tb.sv
// Self-checking bench for the encoder index event block.
// Assumes eic_top, the encoder model and the port checker.
`timescale 1ns/10ps
`default_nettype none
module encoder_index_event_config_tb
  import eic_pkg::*;
;
  localparam logic [7:0] A_CFG = {EIC_IDX_CONFIG, 2'h0};
  localparam logic [7:0] A_RST = {EIC_IDX_RST_VAL, 2'h0};
  localparam logic [7:0] A_POS = {EIC_IDX_POS, 2'h0};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  eic_axi_req_t axi_req = '0;
  eic_axi_rsp_t axi_rsp;
  logic [31:0] step_pos = 32'h0000_1000;
  logic [31:0] enc_pos, enc_latch, step_latch;
  logic dec_mode, pulse, pin_a, pin_b, pin_n;
  int fails = 0;
  int n_tests = 0;
  // Holds rready low until rvalid is seen, to exercise the read hold
  logic rd_late = 1'b0;
  always #25 clk_sys = ~clk_sys;
  eic_top i_dut (.clk_sys(clk_sys), .srst(srst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .enc_a_pin(pin_a), .enc_b_pin(pin_b),
    .enc_n_pin(pin_n), .actual_step_position(step_pos),
    .enc_pos(enc_pos), .enc_latch(enc_latch), .step_latch(step_latch),
    .enc_decimal_mode(dec_mode), .index_pulse(pulse));
  eic_enc_model i_enc (.enc_a(pin_a), .enc_b(pin_b), .enc_n(pin_n));
  // ******
  // Common tasks
  // ******
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task check(input string name, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task hang();
    fails++;
    $display("[FAIL] bus answer expected 1 seen 0");
    end_sim();
  endtask : hang
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    repeat (40) begin
      @(posedge clk_sys);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= !rd_late;
    repeat (40) begin
      @(posedge clk_sys);
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid && !axi_req.rready) begin
        axi_req.rready <= 1'b1;
      end else if (axi_rsp.rvalid) begin
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd
  task cfg(input logic [31:0] v);
    logic [1:0] r;
    wr(A_CFG, v, r);
    check("config write resp", r, EIC_RESP_OKAY);
  endtask : cfg
  // Holds N active four cycles and counts index pulses
  task pulse_n(input logic pol, output int cnt);
    cnt = 0;
    @(posedge clk_sys);
    i_enc.set_n(pol);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (i == 3)
        i_enc.set_n(!pol);
      if (pulse === 1'b1)
        cnt++;
    end
  endtask : pulse_n
  // ******
  // Scenarios
  // ******
  task t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(A_CFG, d, r);
    check("config reset", d, 32'h0000_0400);
    wr(A_CFG, 32'h5A5A_0401, r);
    rd(A_CFG, d, r);
    check("config readback", d, 32'h5A5A_0401);
    check("decimal on", dec_mode, 32'h1);
    cfg(32'h0000_0400);
    check("decimal off", dec_mode, 32'h0);
    rd_late = 1'b1;
    rd(8'h3C, d, r);
    rd_late = 1'b0;
    check("unmapped resp", r, EIC_RESP_SLVERR);
    check("unmapped data", d, 32'h0);
  endtask : t_regs
  task t_sens();
    int c;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk_sys);
        i_enc.set_n(!p[0]);
        cyc(4);
        cfg(32'h200 | (32'(p) << 4) | (32'(s) << 5));
        cyc(4);
        pulse_n(p[0], c);
        check("sens pulses", c, s == 0 ? 4 : (s == 3 ? 2 : 1));
      end
    end
  endtask : t_sens
  task t_gate();
    int c;
    logic a, b;
    for (int q = 0; q < 4; q++) begin
      a = q[1];
      b = q[1] ^ q[0];
      for (int k = 0; k < 4; k++) begin
        cfg(32'h30 | (32'(a ^ k[0]) << 7) | (32'(b ^ (k == 2)) << 8)
          | (32'(k == 3) << 9));
        pulse_n(1'b1, c);
        check("gated pulses", c, (k == 0 || k == 3) ? 1 : 0);
      end
      @(posedge clk_sys);
      i_enc.step();
      cyc(4);
    end
  endtask : t_gate
  task t_once();
    int c;
    logic [31:0] d;
    logic [1:0] r;
    wr(A_RST, 32'h0000_0055, r);
    wr(A_POS, 32'h0000_0123, r);
    cfg(32'h0000_063A);
    pulse_n(1'b1, c);
    check("once pos", enc_pos, 32'h0000_0055);
    check("once latch", enc_latch, 32'h0000_0123);
    check("once step", step_latch, 32'h0);
    rd(A_CFG, d, r);
    check("once bit cleared", d, 32'h0000_0632);
    wr(A_POS, 32'h0000_0200, r);
    pulse_n(1'b1, c);
    check("second pos", enc_pos, 32'h0000_0200);
    check("second latch", enc_latch, 32'h0000_0123);
  endtask : t_once
  task t_cont();
    int c;
    logic [1:0] r;
    for (int i = 0; i < 3; i++) begin
      cfg(i == 0 ? 32'h0000_0E34 : 32'h0000_0E36);
      wr(A_POS, 32'h77 + 32'(i), r);
      @(posedge clk_sys);
      step_pos <= 32'h2222 + 32'(i);
      pulse_n(1'b1, c);
      check("cont pos", enc_pos, i == 0 ? 32'h77 : 32'h55);
      check("cont latch", enc_latch, 32'h77 + 32'(i));
      check("cont step", step_latch, 32'h2222 + 32'(i));
    end
  endtask : t_cont
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    cyc(2);
    t_regs();
    t_sens();
    t_gate();
    t_once();
    t_cont();
    end_sim();
  end
endmodule : encoder_index_event_config_tb
bind eic_top eic_top_chk i_chk (.clk_sys(clk_sys), .srst(srst),
  .axi_req(axi_req), .axi_rsp(axi_rsp),
  .actual_step_position(actual_step_position), .enc_pos(enc_pos),
  .enc_latch(enc_latch), .step_latch(step_latch),
  .enc_decimal_mode(enc_decimal_mode), .index_pulse(index_pulse));
`default_nettype wire
